// ### hdl/dbq_defines.svh
// Offsets, field sizes, reset values and response codes of the block.
//
// How it works
// - Four doorbells, each own status and clear.
// - Doorbell status holds 16 bits; upper half reserved.
// - Status read-only, resets zero, reserved reads zero.
// - Doorbell clear bits drop matching status bits.
// - Receive queue status: bit k is queue k.
// - Receive queue clear bit k drops queue k.
`ifndef DBQ_DEFINES_SVH
`define DBQ_DEFINES_SVH

// Register byte offsets on the bus.
`define DBQ_OFF_DB_STATUS_BASE 8'h00
`define DBQ_OFF_DB_CLEAR_BASE 8'h10
`define DBQ_OFF_RX_STATUS 8'h20
`define DBQ_OFF_RX_CLEAR 8'h24
`define DBQ_OFF_MASK_BASE 8'h30
`define DBQ_WORD_BYTES 4

// Field sizes and counts.
`define DBQ_COND_BITS 16
`define DBQ_DOORBELLS 4
`define DBQ_GROUPS 5
`define DBQ_DATA_BITS 32
`define DBQ_LANE_BITS 8

// Reset values.
`define DBQ_STATUS_RESET 16'h0000
`define DBQ_MASK_RESET 16'h0000
`define DBQ_RDATA_RESET 32'h0000_0000

// Bus response codes.
`define DBQ_RESP_OKAY 2'h0
`define DBQ_RESP_SLVERR 2'h2

`endif

// ### hdl/dbq_irq_status.sv
// Doorbell and receive queue interrupt status with AXI4-Lite registers.
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`include "dbq_defines.svh"

module dbq_irq_status #(
    parameter int ADDR_W = 8,
    parameter int COND_W = `DBQ_COND_BITS
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [`DBQ_DOORBELLS*COND_W-1:0] doorbell_set,
    input wire logic [COND_W-1:0] rx_queue_set,
    output logic irq
);

    localparam int NGRP = `DBQ_GROUPS;
    localparam int NDB = `DBQ_DOORBELLS;
    localparam int DW = `DBQ_DATA_BITS;

    // Map a bus address to a register kind and group; used by both paths.
    function automatic dbq_pkg::dbq_dec_t dbq_decode(
        input logic [ADDR_W-1:0] addr
    );
        dbq_pkg::dbq_dec_t d;
        logic [ADDR_W-1:0] word;
        logic [ADDR_W-1:0] st;
        logic [ADDR_W-1:0] cl;
        logic [ADDR_W-1:0] mk;
        d.kind = dbq_pkg::DBQ_K_NONE;
        d.grp = 3'h0;
        word = {addr[ADDR_W-1:2], 2'b00};
        for (int g = 0; g < NGRP; g++) begin
            if (g < NDB) begin
                st = ADDR_W'(`DBQ_OFF_DB_STATUS_BASE
                     + `DBQ_WORD_BYTES * g);
                cl = ADDR_W'(`DBQ_OFF_DB_CLEAR_BASE
                     + `DBQ_WORD_BYTES * g);
            end else begin
                st = ADDR_W'(`DBQ_OFF_RX_STATUS);
                cl = ADDR_W'(`DBQ_OFF_RX_CLEAR);
            end
            mk = ADDR_W'(`DBQ_OFF_MASK_BASE + `DBQ_WORD_BYTES * g);
            if (word == st) begin
                d.kind = dbq_pkg::DBQ_K_STATUS;
                d.grp = 3'(g);
            end else if (word == cl) begin
                d.kind = dbq_pkg::DBQ_K_CLEAR;
                d.grp = 3'(g);
            end else if (word == mk) begin
                d.kind = dbq_pkg::DBQ_K_MASK;
                d.grp = 3'(g);
            end
        end
        return d;
    endfunction : dbq_decode

    logic [ADDR_W-1:0] aw_addr_reg;
    logic [ADDR_W-1:0] aw_addr_next;
    logic aw_full_reg;
    logic aw_full_next;
    logic [COND_W-1:0] w_data_reg;
    logic [COND_W-1:0] w_data_next;
    logic [3:0] w_strb_reg;
    logic [3:0] w_strb_next;
    logic w_full_reg;
    logic w_full_next;
    logic bvalid_reg;
    logic bvalid_next;
    logic [1:0] bresp_reg;
    logic [1:0] bresp_next;
    logic rvalid_reg;
    logic rvalid_next;
    logic [DW-1:0] rdata_reg;
    logic [DW-1:0] rdata_next;
    logic [1:0] rresp_reg;
    logic [1:0] rresp_next;
    logic [COND_W-1:0] mask_reg [NGRP];
    logic [COND_W-1:0] mask_next [NGRP];
    logic irq_reg;
    logic irq_next;

    logic [COND_W-1:0] status [NGRP];
    logic [COND_W-1:0] set_vec [NGRP];
    logic [COND_W-1:0] clear_vec [NGRP];
    logic [COND_W-1:0] lane_en;
    logic do_write;
    dbq_pkg::dbq_dec_t wr_dec;
    dbq_pkg::dbq_dec_t rd_dec;

    // One write and one read may be in flight; a held response stalls more.
    assign s_axi_awready = ~aw_full_reg & ~bvalid_reg;
    assign s_axi_wready = ~w_full_reg & ~bvalid_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign irq = irq_reg;

    // Event inputs from the doorbell decoder and the queue completion logic.
    generate
        for (genvar g = 0; g < NGRP; g++) begin : g_bank
            if (g < NDB) begin : g_db
                assign set_vec[g] = doorbell_set[g*COND_W +: COND_W];
            end else begin : g_rx
                assign set_vec[g] = rx_queue_set;
            end
            dbq_sticky_bank #(
                .WIDTH(COND_W)
            ) u_bank (
                .mclk(mclk),
                .arst_n(arst_n),
                .set_in(set_vec[g]),
                .clear_in(clear_vec[g]),
                .status(status[g])
            );
        end
    endgenerate

    // Bus slave: address and data are caught in either order, the write
    // acts once both are held, and reads answer one cycle after they land.
    always_comb begin
        aw_addr_next = aw_addr_reg;
        aw_full_next = aw_full_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        w_full_next = w_full_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        mask_next = mask_reg;
        irq_next = 1'b0;
        wr_dec = dbq_decode(aw_addr_reg);
        rd_dec = dbq_decode(s_axi_araddr);
        do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
        for (int b = 0; b < COND_W; b++) begin
            lane_en[b] = w_strb_reg[b / `DBQ_LANE_BITS];
        end
        for (int g = 0; g < NGRP; g++) begin
            clear_vec[g] = '0;
            // Only ones in an enabled byte lane clear; zeros do nothing.
            if (do_write && wr_dec.kind == dbq_pkg::DBQ_K_CLEAR
                    && wr_dec.grp == 3'(g)) begin
                clear_vec[g] = w_data_reg & lane_en;
            end
            irq_next = irq_next | (|(status[g] & mask_reg[g]));
        end
        if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_next = s_axi_awaddr;
            aw_full_next = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_data_next = s_axi_wdata[COND_W-1:0];
            w_strb_next = s_axi_wstrb;
            w_full_next = 1'b1;
        end
        if (do_write) begin
            aw_full_next = 1'b0;
            w_full_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = `DBQ_RESP_OKAY;
            if (wr_dec.kind == dbq_pkg::DBQ_K_NONE) begin
                bresp_next = `DBQ_RESP_SLVERR;
            end
            // Writes to status words are accepted and ignored.
            if (wr_dec.kind == dbq_pkg::DBQ_K_MASK) begin
                mask_next[wr_dec.grp] = (mask_reg[wr_dec.grp] & ~lane_en)
                                      | (w_data_reg & lane_en);
            end
        end
        if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rresp_next = `DBQ_RESP_OKAY;
            rdata_next = '0;
            unique case (rd_dec.kind)
                dbq_pkg::DBQ_K_STATUS: begin
                    rdata_next = DW'(status[rd_dec.grp]);
                end
                dbq_pkg::DBQ_K_MASK: begin
                    rdata_next = DW'(mask_reg[rd_dec.grp]);
                end
                dbq_pkg::DBQ_K_CLEAR: begin
                    rdata_next = '0;
                end
                dbq_pkg::DBQ_K_NONE: begin
                    rresp_next = `DBQ_RESP_SLVERR;
                end
            endcase
        end
    end

    // Registers of the bus slave, the masks and the interrupt line.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            aw_addr_reg <= '0;
            aw_full_reg <= 1'b0;
            w_data_reg <= '0;
            w_strb_reg <= 4'h0;
            w_full_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `DBQ_RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= `DBQ_RDATA_RESET;
            rresp_reg <= `DBQ_RESP_OKAY;
            for (int g = 0; g < NGRP; g++) begin
                mask_reg[g] <= COND_W'(`DBQ_MASK_RESET);
            end
            irq_reg <= 1'b0;
        end else begin
            aw_addr_reg <= aw_addr_next;
            aw_full_reg <= aw_full_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            w_full_reg <= w_full_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            mask_reg <= mask_next;
            irq_reg <= irq_next;
        end
    end

endmodule : dbq_irq_status

// ### hdl/dbq_pkg.sv
// Types shared by the interrupt status block.
package dbq_pkg;

    // What a bus address selects.
    typedef enum logic [1:0] {
        DBQ_K_NONE = 2'b00,
        DBQ_K_STATUS = 2'b01,
        DBQ_K_CLEAR = 2'b10,
        DBQ_K_MASK = 2'b11
    } dbq_kind_t;

    // Decoded address: register kind and group (0-3 doorbell, 4 queue).
    typedef struct packed {
        dbq_kind_t kind;
        logic [2:0] grp;
    } dbq_dec_t;

endpackage : dbq_pkg

// ### hdl/dbq_sticky_bank.sv
// One bank of sticky condition bits with per-bit set and clear.
`include "dbq_defines.svh"

module dbq_sticky_bank #(
    parameter int WIDTH = `DBQ_COND_BITS
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] set_in,
    input wire logic [WIDTH-1:0] clear_in,
    output logic [WIDTH-1:0] status
);

    logic [WIDTH-1:0] status_reg;
    logic [WIDTH-1:0] status_next;

    // A set in the same cycle as its clear wins, so no event is lost.
    always_comb begin
        status_next = (status_reg & ~clear_in) | set_in;
    end

    // Status bits start at zero after reset.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            status_reg <= WIDTH'(`DBQ_STATUS_RESET);
        end else begin
            status_reg <= status_next;
        end
    end

    assign status = status_reg;

endmodule : dbq_sticky_bank

// ### testbench/dbq_irq_status_monitor.sv
// Port-level checks for the doorbell and receive queue status block.
module dbq_irq_monitor #(
    parameter int ADDR_W = 8,
    parameter int COND_W = 16
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic [COND_W-1:0] rx_queue_set,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [COND_W-1:0] set_d_reg;
    logic ar_ok;

    // A set one edge old must already be visible to a status read.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            set_d_reg <= '0;
        end else begin
            set_d_reg <= rx_queue_set;
        end
    end
    assign ar_ok = s_axi_arvalid && s_axi_arready;

    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);

    a_read_answer: assert property (ar_ok |=> s_axi_rvalid)
        else $error("read request not answered");
    a_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("second read accepted");
    a_upper_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("reserved half not zero");
    a_set_seen: assert property (ar_ok && s_axi_araddr == 8'h20 |=>
        (s_axi_rdata[COND_W-1:0] & $past(set_d_reg)) == $past(set_d_reg))
        else $error("queue set bit lost");
    a_clear_zero: assert property (
        ar_ok && s_axi_araddr[7:4] == 4'h1 |=> s_axi_rdata == 32'h0)
        else $error("clear register read not zero");
    a_unmapped_err: assert property (ar_ok && s_axi_araddr >= 8'h44 |=>
        s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_mapped_okay: assert property (
        ar_ok && s_axi_araddr < 8'h28 |=> s_axi_rresp == 2'h0)
        else $error("mapped read refused");
    a_write_busy: assert property (
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    c_queue_read: cover property (ar_ok && s_axi_araddr == 8'h20);
    c_irq_rise: cover property ($rose(irq));
    c_error: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : dbq_irq_monitor

bind dbq_irq_status dbq_irq_monitor #(
    .ADDR_W(ADDR_W),
    .COND_W(COND_W)
) u_mon (
    .mclk,
    .arst_n,
    .s_axi_awready,
    .s_axi_wready,
    .s_axi_bvalid,
    .s_axi_araddr,
    .s_axi_arvalid,
    .s_axi_arready,
    .s_axi_rdata,
    .s_axi_rresp,
    .s_axi_rvalid,
    .rx_queue_set,
    .irq
);

// ### testbench/test_dbq_irq_status.sv
// Self-checking bench for the doorbell and receive queue status block.
module test_dbq_irq_status;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [63:0] doorbell_set = 64'h0;
    logic [15:0] rx_queue_set = 16'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, got;
    logic [15:0] model [5] = '{default: 16'h0};
    logic [15:0] msk [5] = '{default: 16'h0};
    int bad_count = 0, checked = 0, seed = 32'h8306;

    // The clock toggles every half period of 25 ns.
    always #12.5 mclk = ~mclk;

    dbq_irq_status dut (.mclk, .arst_n, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .doorbell_set, .rx_queue_set, .irq);

    function automatic logic [7:0] sa(input int g);
        return (g < 4) ? 8'(4 * g) : 8'h20;
    endfunction : sa

    function automatic logic [7:0] ca(input int g);
        return (g < 4) ? 8'(16 + 4 * g) : 8'h24;
    endfunction : ca

    // Only bytes whose strobe is set may clear status bits.
    function automatic logic [15:0] lanes(input logic [3:0] s);
        return {{8{s[1]}}, {8{s[0]}}};
    endfunction : lanes

    function automatic logic exp_irq();
        logic r = 1'b0;
        for (int k = 0; k < 5; k++) r |= |(model[k] & msk[k]);
        return r;
    endfunction : exp_irq

    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        checked++;
        if (a !== e) begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
        end
    endtask : chk

    // Address and data go out together; each drops once it is taken.
    // The response ready stays high afterwards, so back to back calls
    // never drive it twice in one time step.
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        got = s_axi_rdata;
    endtask : rd

    task automatic pulse(input int g, input logic [15:0] v);
        if (g < 4) doorbell_set[16*g +: 16] <= v;
        else rx_queue_set <= v;
        @(posedge mclk);
        doorbell_set <= 64'h0;
        rx_queue_set <= 16'h0;
        model[g] = model[g] | v;
    endtask : pulse

    // The interrupt follows a status or mask change by one cycle.
    task automatic irq_chk();
        repeat (2) @(posedge mclk);
        chk({31'h0, irq}, {31'h0, exp_irq()});
    endtask : irq_chk

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done

    // Main sequence: reset values, random traffic, corner cases, interrupt.
    initial begin
        logic [31:0] d;
        logic [15:0] v;
        logic [3:0] s;
        int g;
        repeat (10) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        for (g = 0; g < 5; g++) begin
            rd(sa(g));
            chk(got, 32'h0);
            rd(ca(g));
            chk(got, 32'h0);
        end
        rd(8'h44);
        chk({got[31:2], s_axi_rresp}, 32'h2);
        wr(8'h48, 32'hffff, 4'hf);
        chk({30'h0, s_axi_bresp}, 32'h2);
        $display("reset and map test done");
        for (int i = 0; i < 60; i++) begin
            g = $unsigned($random(seed)) % 5;
            v = $random(seed);
            d = $random(seed);
            s = $random(seed);
            pulse(g, v);
            wr(sa(g), d, 4'hf);
            rd(sa(g));
            chk(got, {16'h0, model[g]});
            wr(ca(g), d, s);
            model[g] &= ~(d[15:0] & lanes(s));
            rd(sa(g));
            chk(got, {16'h0, model[g]});
        end
        $display("random set and clear test done");
        // The set stands only at the clear's edge and the one before, so a
        // clear that won would leave these bits low.
        rx_queue_set <= 16'h8001;
        fork
            wr(ca(4), 32'h8001, 4'hf);
            begin
                repeat (2) @(posedge mclk);
                rx_queue_set <= 16'h0;
            end
        join
        model[4] |= 16'h8001;
        rd(sa(4));
        chk(got, {16'h0, model[4]});
        // A set held over the edge before the request must show in that same read.
        rx_queue_set <= 16'h0100;
        @(posedge mclk);
        rd(sa(4));
        rx_queue_set <= 16'h0;
        model[4] |= 16'h0100;
        chk(got, {16'h0, model[4]});
        $display("set against clear test done");
        for (g = 0; g < 5; g++) begin
            wr(ca(g), 32'hffff, 4'hf);
            model[g] = 16'h0;
        end
        pulse(2, 16'h0010);
        irq_chk();
        wr(8'h38, 32'h0010, 4'hf);
        msk[2] = 16'h0010;
        irq_chk();
        rd(8'h38);
        chk(got, 32'h0000_0010);
        wr(ca(2), 32'h0010, 4'hf);
        model[2] = 16'h0;
        irq_chk();
        $display("interrupt test done");
        // A reset in mid-run must drop pending bits, masks and the line.
        pulse(2, 16'h0010);
        irq_chk();
        arst_n <= 1'b0;
        model = '{default: 16'h0};
        msk = '{default: 16'h0};
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        chk({31'h0, irq}, 32'h0);
        rd(sa(2));
        chk(got, 32'h0);
        rd(8'h38);
        chk(got, 32'h0);
        $display("mid-run reset test done");
        test_done();
    end

    // A hang is cut short well beyond the expected run length.
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        test_done();
    end
endmodule : test_dbq_irq_status
